// >>> rtl/ips_regs.vh
// ips_regs.vh: register map, field layout, selector codes and bus answers
// of the serial-group input pin select block.
// assumes: included by bare name from the rtl files of the ips block.
`ifndef IPS_REGS_VH
`define IPS_REGS_VH

// bus geometry
`define IPS_ADDR_W        8
`define IPS_NUM_REGS      6
`define IPS_NUM_FIELDS    8

// register byte offsets, one aligned 32-bit word each
`define IPS_OFF_UART_A    8'h00
`define IPS_OFF_UART_B    8'h04
`define IPS_OFF_SPI_CD    8'h08
`define IPS_OFF_SPI_SS    8'h0C
`define IPS_OFF_CODEC_CD  8'h10
`define IPS_OFF_CODEC_FS  8'h14

// register indices
`define IPS_IDX_UART_A    3'h0
`define IPS_IDX_UART_B    3'h1
`define IPS_IDX_SPI_CD    3'h2
`define IPS_IDX_SPI_SS    3'h3
`define IPS_IDX_CODEC_CD  3'h4
`define IPS_IDX_CODEC_FS  3'h5

// field layout: seven-bit selectors in bits 6-0 and, where present, 14-8
`define IPS_FIELD_W       7
`define IPS_LO_LSB        4'h0
`define IPS_HI_LSB        4'h8
`define IPS_MASK_SINGLE   16'h007F
`define IPS_MASK_DUAL     16'h7F7F
`define IPS_RESET         16'h0000

// selector codes
`define IPS_CODE_GROUND   7'h00
`define IPS_CODE_CMP      7'h01
`define IPS_CODE_TOP_PIN  7'h7C

// first and last remappable pin numbers reachable by a code
`define IPS_PIN_LO        2
`define IPS_PIN_HI        124

// bus answers
`define IPS_RESP_OKAY     2'h0
`define IPS_RESP_SLVERR   2'h2

`endif

// >>> rtl/ips_source_mux.v
// ips_source_mux: one peripheral input source selector, registered output.
// assumes: pins and comparator are synchronous to clk; sel is a stable
// register value.
`timescale 1ns/1ps
`default_nettype none
`include "ips_regs.vh"

module ips_source_mux (
    // clock and reset
    input  wire                      clk,
    input  wire                      resetn,
    // selector and candidate sources
    input  wire [`IPS_FIELD_W-1:0]   sel,
    input  wire                      cmp_in,
    input  wire [`IPS_PIN_HI:`IPS_PIN_LO] pin_in,
    // routed peripheral input
    output reg                       src_out
);

    reg src_d;

    // source choice; undocumented codes above the top pin fall back to ground
    always @* begin
        if (sel == `IPS_CODE_GROUND) begin
            src_d = 1'b0;
        end else if (sel == `IPS_CODE_CMP) begin
            src_d = cmp_in;
        end else if (sel <= `IPS_CODE_TOP_PIN) begin
            src_d = pin_in[sel];
        end else begin
            src_d = 1'b0;
        end
    end

    // registered so the peripheral never sees a glitch while sel changes
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            src_out <= 1'b0;
        end else begin
            src_out <= src_d;
        end
    end

endmodule
`default_nettype wire

// >>> rtl/ips_input_select.v
// ips_input_select: input pin remapping for the serial peripheral group,
// with six selector registers behind an AXI4-Lite slave.
// assumes: one 50 MHz clock, all pins and comparator synchronous to it,
// master keeps at most one write and one read in flight.
//
// Function
// - seven-bit selectors, read/write, reset to zero
// - unimplemented bits read back as zero
// - code zero ties input to ground
// - code one selects comparator one output
// - top code selects remappable pin 124
// - register 18 low field: uart A receive
// - register 19 low field: uart B receive
// - register 22 high field: spi B clock
// - register 22 low field: spi B data
// - register 23 low field: spi B select
// - register 24 high field: codec clock
// - register 24 low field: codec data
// - register 25 low field: codec frame sync
`timescale 1ns/1ps
`default_nettype none
`include "ips_regs.vh"

module ips_input_select (
    // clock and reset
    input  wire                      clk,
    input  wire                      resetn,
    // axi4-lite write address channel
    input  wire [`IPS_ADDR_W-1:0]    s_axi_awaddr,
    input  wire                      s_axi_awvalid,
    output wire                      s_axi_awready,
    // axi4-lite write data channel
    input  wire [31:0]               s_axi_wdata,
    input  wire [3:0]                s_axi_wstrb,
    input  wire                      s_axi_wvalid,
    output wire                      s_axi_wready,
    // axi4-lite write response channel
    output reg  [1:0]                s_axi_bresp,
    output reg                       s_axi_bvalid,
    input  wire                      s_axi_bready,
    // axi4-lite read address channel
    input  wire [`IPS_ADDR_W-1:0]    s_axi_araddr,
    input  wire                      s_axi_arvalid,
    output wire                      s_axi_arready,
    // axi4-lite read data channel
    output reg  [31:0]               s_axi_rdata,
    output reg  [1:0]                s_axi_rresp,
    output reg                       s_axi_rvalid,
    input  wire                      s_axi_rready,
    // candidate sources
    input  wire                      comparator_one_output,
    input  wire [`IPS_PIN_HI:`IPS_PIN_LO] remappable_pin_in,
    // routed peripheral inputs
    output wire                      uart_a_receive_input,
    output wire                      uart_b_receive_input,
    output wire                      spi_b_clock_input,
    output wire                      spi_b_data_input,
    output wire                      spi_b_slave_select_input,
    output wire                      codec_clock_input,
    output wire                      codec_data_input,
    output wire                      codec_frame_sync_input
);

    // field table: register index (3 bits) and lsb (4 bits) per routed input,
    // entry 0 in the low bits; order matches routed_w below
    localparam [23:0] FIELD_REG = {
        `IPS_IDX_CODEC_FS,
        `IPS_IDX_CODEC_CD,
        `IPS_IDX_CODEC_CD,
        `IPS_IDX_SPI_SS,
        `IPS_IDX_SPI_CD,
        `IPS_IDX_SPI_CD,
        `IPS_IDX_UART_B,
        `IPS_IDX_UART_A
    };
    localparam [31:0] FIELD_LSB = {
        `IPS_LO_LSB, `IPS_LO_LSB, `IPS_HI_LSB, `IPS_LO_LSB,
        `IPS_LO_LSB, `IPS_HI_LSB, `IPS_LO_LSB, `IPS_LO_LSB
    };

    // selector storage, one 16-bit word per register
    reg  [15:0]                 sel_q [0:`IPS_NUM_REGS-1];

    // write side holding registers; address and data may arrive in any order
    reg                         aw_have_q;
    reg  [`IPS_ADDR_W-1:0]      aw_addr_q;
    reg                         w_have_q;
    reg  [31:0]                 w_data_q;
    reg  [3:0]                  w_strb_q;

    // decode results
    reg  [2:0]                  wr_idx;
    reg                         wr_hit;
    reg  [2:0]                  rd_idx;
    reg                         rd_hit;
    reg  [15:0]                 wr_mask;
    reg  [15:0]                 wr_merged;

    wire                        wr_fire;
    wire [`IPS_NUM_FIELDS-1:0]  routed_w;

    // address to register index; misaligned or out-of-map addresses miss
    function [3:0] ips_decode;
        input [`IPS_ADDR_W-1:0] addr;
        begin
            case (addr)
                `IPS_OFF_UART_A:   ips_decode = {1'b1, `IPS_IDX_UART_A};
                `IPS_OFF_UART_B:   ips_decode = {1'b1, `IPS_IDX_UART_B};
                `IPS_OFF_SPI_CD:   ips_decode = {1'b1, `IPS_IDX_SPI_CD};
                `IPS_OFF_SPI_SS:   ips_decode = {1'b1, `IPS_IDX_SPI_SS};
                `IPS_OFF_CODEC_CD: ips_decode = {1'b1, `IPS_IDX_CODEC_CD};
                `IPS_OFF_CODEC_FS: ips_decode = {1'b1, `IPS_IDX_CODEC_FS};
                default:           ips_decode = 4'h0;
            endcase
        end
    endfunction

    // implemented bits per register; everything else is forced to zero
    function [15:0] ips_mask;
        input [2:0] idx;
        begin
            case (idx)
                `IPS_IDX_SPI_CD:   ips_mask = `IPS_MASK_DUAL;
                `IPS_IDX_CODEC_CD: ips_mask = `IPS_MASK_DUAL;
                default:           ips_mask = `IPS_MASK_SINGLE;
            endcase
        end
    endfunction

    // a write channel is ready only while its holding slot is empty and no
    // response is waiting, so at most one write is ever in flight; read address only while no read data waits
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

    // write decode and byte-lane merge
    always @* begin
        {wr_hit, wr_idx} = ips_decode(aw_addr_q);
        {rd_hit, rd_idx} = ips_decode(s_axi_araddr);
        wr_mask          = ips_mask(wr_idx);
        wr_merged        = sel_q[wr_idx];
        if (w_strb_q[0]) begin
            wr_merged[7:0] = w_data_q[7:0];
        end
        if (w_strb_q[1]) begin
            wr_merged[15:8] = w_data_q[15:8];
        end
        wr_merged = wr_merged & wr_mask;
    end

    // write address and data capture
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= {`IPS_ADDR_W{1'b0}};
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    // write response; unmapped addresses answer slverr and store nothing
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `IPS_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `IPS_RESP_OKAY : `IPS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // selector registers, cleared at reset so every input starts grounded
    genvar r;
    generate
        for (r = 0; r < `IPS_NUM_REGS; r = r + 1) begin : g_reg
            always @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    sel_q[r] <= `IPS_RESET;
                end else if (wr_fire && wr_hit && ({29'd0, wr_idx} == r)) begin
                    sel_q[r] <= wr_merged;
                end
            end
        end
    endgenerate

    // read path; data comes from a flip-flop, upper half always zero
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `IPS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (rd_hit) begin
                s_axi_rdata <= {16'h0000, sel_q[rd_idx]};
                s_axi_rresp <= `IPS_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `IPS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // one source selector per routed peripheral input
    genvar f;
    generate
        for (f = 0; f < `IPS_NUM_FIELDS; f = f + 1) begin : g_mux
            ips_source_mux u_mux (
                .clk     (clk),
                .resetn  (resetn),
                .sel     (sel_q[FIELD_REG[f*3 +: 3]][FIELD_LSB[f*4 +: 4] +: `IPS_FIELD_W]),
                .cmp_in  (comparator_one_output),
                .pin_in  (remappable_pin_in),
                .src_out (routed_w[f])
            );
        end
    endgenerate

    // routed inputs by table order
    assign uart_a_receive_input     = routed_w[0];
    assign uart_b_receive_input     = routed_w[1];
    assign spi_b_clock_input        = routed_w[2];
    assign spi_b_data_input         = routed_w[3];
    assign spi_b_slave_select_input = routed_w[4];
    assign codec_clock_input        = routed_w[5];
    assign codec_data_input         = routed_w[6];
    assign codec_frame_sync_input   = routed_w[7];

endmodule
`default_nettype wire

// >>> testbench/ips_src_model.sv
// ips_src_model: far side of the block, comparator and remappable pins.
// assumes: bench sets the wanted levels; pins are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module ips_src_model (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         resetn,
    // levels wanted by the bench
    input  wire logic         cmp_set,
    input  wire logic [124:2] pin_set,
    // levels shown to the block
    output var  logic         cmp_out,
    output var  logic [124:2] pin_out
);
    // sources move only on edges, the block expects synchronous pins
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cmp_out <= 1'b0;
            pin_out <= '0;
        end else begin
            cmp_out <= cmp_set;
            pin_out <= pin_set;
        end
    end
endmodule

`default_nettype wire

// >>> testbench/ips_input_select_checker.sv
// ips_input_select_checker: bus and reset properties at the top ports.
// assumes: bound to ips_input_select, one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "ips_regs.vh"

module ips_chk (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // routed inputs
    input wire logic        uart_a_receive_input,
    input wire logic        codec_frame_sync_input
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_reset_ground: assert property ($rose(resetn) |-> !uart_a_receive_input && !codec_frame_sync_input)
        else $error("routed input not grounded after reset");
    a_unimpl_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[7])
        else $error("unimplemented read bits not zero");
    a_err_data: assert property (s_axi_rvalid && s_axi_rresp != `IPS_RESP_OKAY |-> s_axi_rdata == 32'h0)
        else $error("refused read returned data");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");

    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `IPS_RESP_SLVERR);
    c_rstall: cover property (s_axi_rvalid && !s_axi_rready);
    c_restart: cover property ($rose(resetn));
endmodule

bind ips_input_select ips_chk u_chk (.clk, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .uart_a_receive_input, .codec_frame_sync_input);

`default_nettype wire

// >>> testbench/tb.sv
// tb: register and routing tests of the input pin select block.
// assumes: ips_src_model drives the sources, checker bound separately.
`timescale 1ns/1ps
`default_nettype none
`include "ips_regs.vh"

module tb;
    logic clk = 1'b0, resetn = 1'b0, cmp_set = 1'b0;
    logic [124:2] pin_set = '0, pins;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ex;
    wire logic [7:0] outs;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cmp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0] fa [8] = '{8'h00, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h10, 8'h10, 8'h14};
    int fl [8] = '{0, 0, 8, 0, 0, 8, 0, 0};
    logic [6:0] cd [6] = '{7'h00, 7'h01, 7'h02, 7'h3F, 7'h7C, 7'h7F};
    int err_total = 0, n_tests = 0;

    ips_src_model u_src (.clk(clk), .resetn(resetn), .cmp_set(cmp_set), .pin_set(pin_set),
        .cmp_out(cmp), .pin_out(pins));
    ips_input_select uut (.clk(clk), .resetn(resetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .comparator_one_output(cmp), .remappable_pin_in(pins),
        .uart_a_receive_input(outs[0]), .uart_b_receive_input(outs[1]),
        .spi_b_clock_input(outs[2]), .spi_b_data_input(outs[3]),
        .spi_b_slave_select_input(outs[4]), .codec_clock_input(outs[5]),
        .codec_data_input(outs[6]), .codec_frame_sync_input(outs[7]));

    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, g, e);
        end
    endtask

    // request and response ready rise together; each holds until its own edge,
    // only the watchdog ends a wait that never finishes
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
        end
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            rd(8'(i * 4), 32'h0, `IPS_RESP_OKAY);
            wr(8'(i * 4), 32'hFFFFFFFF, 4'hF, `IPS_RESP_OKAY);
            rd(8'(i * 4), (i == 2 || i == 4) ? 32'h7F7F : 32'h7F, `IPS_RESP_OKAY);
            wr(8'(i * 4), 32'h0, 4'hF, `IPS_RESP_OKAY);
        end
        $display("test readback done");
        // lane 1 alone must reach only the high field
        wr(8'h10, 32'h7F7F, 4'h2, `IPS_RESP_OKAY);
        rd(8'h10, 32'h7F00, `IPS_RESP_OKAY);
        wr(8'h10, 32'h0, 4'hF, `IPS_RESP_OKAY);
        wr(8'h18, 32'h7F, 4'hF, `IPS_RESP_SLVERR);
        rd(8'h18, 32'h0, `IPS_RESP_SLVERR);
        $display("test lanes and unmapped done");
        // each source toggled both ways so a stuck output cannot pass;
        // codes above the top pin must stay grounded
        for (int f = 0; f < 8; f++) begin
            for (int j = 0; j < 6; j++) begin
                wr(fa[f], 32'(cd[j]) << fl[f], 4'hF, `IPS_RESP_OKAY);
                for (int ph = 0; ph < 2; ph++) begin
                    cmp_set <= ph[0];
                    pin_set <= ph[0] ? ~{41{3'b011}} : {41{3'b011}};
                    repeat (3) @(posedge clk);
                    ex = 8'h00;
                    ex[f] = (cd[j] == `IPS_CODE_GROUND || cd[j] > `IPS_CODE_TOP_PIN) ? 1'b0 :
                            (cd[j] == `IPS_CODE_CMP) ? cmp : pins[cd[j]];
                    chk({24'h0, outs}, {24'h0, ex});
                end
            end
            wr(fa[f], 32'h0, 4'hF, `IPS_RESP_OKAY);
        end
        $display("test routing done");
        // pin 124 is high here, so the reset must visibly pull the input down
        wr(8'h00, 32'h7C, 4'hF, `IPS_RESP_OKAY);
        @(posedge clk);
        chk({24'h0, outs}, 32'h00000001);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(8'h00, 32'h0, `IPS_RESP_OKAY);
        chk({24'h0, outs}, 32'h00000000);
        $display("test second reset done");
        test_done;
    end

    // watchdog, well beyond the fewer than a thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        test_done;
    end
endmodule

`default_nettype wire
